/* File: dv/rca_periph_model.sv */
`timescale 1ns/1ps
`default_nettype none

module rca_periph_model
  import rca_pkg::*;
(
  // clock
  input wire logic core_clk_i,
  // update from the bench
  input wire logic upd_i,
  input wire rca_ctrl_regs_type upd_val_i,
  // registers offered to the core
  output rca_ctrl_regs_type ctrl_regs_o
);
  // contents move only on an explicit update; a read by the core never touches them
  always_ff @(posedge core_clk_i) begin
    if (upd_i) begin
      ctrl_regs_o <= upd_val_i;
    end
  end
endmodule : rca_periph_model

`default_nettype wire

/* File: dv/test_read_ctrl_reg_to_acc_ops.sv */
`timescale 1ns/1ps
`default_nettype none

module test_read_ctrl_reg_to_acc_ops
  import rca_pkg::*;
;
  logic core_clk, resetn, valid, upd;
  logic [9:0] instr;
  rca_core_wr_type core_wr;
  rca_ctrl_regs_type ctrl_regs, upd_val;
  logic [3:0] acc_o, e_acc;
  logic carry_flag_o, exec_done_o, skip_o, e_cy, e_done;
  rca_group_type group_o, e_grp;
  int num_errors, cmp_count;
  logic [9:0] ops [4];
  //////////////////////////////////////////////////////////////////////////////
  rca_periph_model peri (.core_clk_i(core_clk), .upd_i(upd), .upd_val_i(upd_val), .ctrl_regs_o(ctrl_regs));
  rca_read_ctrl dut (.core_clk_i(core_clk), .resetn_i(resetn), .instr_valid_i(valid), .instr_i(instr),
    .ctrl_regs_i(ctrl_regs), .core_wr_i(core_wr), .acc_o(acc_o), .carry_flag_o(carry_flag_o),
    .exec_done_o(exec_done_o), .skip_o(skip_o), .group_o(group_o));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [6:0] pred(input logic [9:0] w, input rca_ctrl_regs_type r);
    case (w)
      RCA_OP_READ_INT_CTRL_ONE: return {1'b1, RCA_GRP_INTERRUPT, r.int_ctrl_reg_one};
      RCA_OP_READ_INT_CTRL_TWO: return {1'b1, RCA_GRP_INTERRUPT, r.int_ctrl_reg_two};
      RCA_OP_READ_TIMER_CTRL_ONE: return {1'b1, RCA_GRP_TIMER, r.timer_ctrl_reg_one};
      RCA_OP_READ_TIMER_CTRL_TWO: return {1'b1, RCA_GRP_TIMER, r.timer_ctrl_reg_two};
      default: return 7'h00;
    endcase
  endfunction : pred

  task automatic chk_acc(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_acc

  task automatic chk_stat(input logic [4:0] got, input logic [4:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_stat

  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  // check last cycle's outcome, then drive the next cycle and predict it
  task automatic cycle(input logic rn, input logic v, input logic [9:0] w, input rca_core_wr_type cw);
    logic [6:0] p;
    @(negedge core_clk);
    chk_acc(acc_o, e_acc);
    chk_stat({carry_flag_o, exec_done_o, skip_o, group_o}, {e_cy, e_done, 1'b0, e_grp});
    resetn = rn;
    valid = v;
    instr = w;
    core_wr = cw;
    upd = 1'($urandom_range(1, 0));
    upd_val = rca_ctrl_regs_type'(16'($urandom));
    p = v ? pred(w, ctrl_regs) : 7'h00;
    if (!rn) begin
      {e_acc, e_cy, e_done, e_grp} = {RCA_ACC_RESET, RCA_CARRY_RESET, 1'b0, RCA_GRP_NONE};
    end else begin
      e_done = p[6];
      e_grp = rca_group_type'(p[5:4]);
      if (p[6]) e_acc = p[3:0];
      else if (cw.acc_wr) e_acc = cw.acc_wdata;
      // a read never writes carry, so a coinciding carry write is dropped
      if (!p[6] && cw.carry_wr) e_cy = cw.carry_wdata;
    end
  endtask : cycle

  function automatic logic [9:0] rnd_word();
    case ($urandom_range(2, 0))
      0: return ops[$urandom_range(3, 0)];
      1: return ops[$urandom_range(3, 0)] ^ (10'h001 << $urandom_range(9, 0));
      default: return 10'($urandom);
    endcase
  endfunction : rnd_word
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    #(8 * 3000);
    num_errors++;
    close_out();
  end

  initial begin
    ops = '{RCA_OP_READ_INT_CTRL_ONE, RCA_OP_READ_INT_CTRL_TWO, RCA_OP_READ_TIMER_CTRL_ONE, RCA_OP_READ_TIMER_CTRL_TWO};
    {resetn, valid, instr, core_wr, upd, upd_val} = {1'b0, 1'b0, 10'h000, 7'h00, 1'b1, 16'hA5C3};
    {e_acc, e_cy, e_done, e_grp} = {RCA_ACC_RESET, RCA_CARRY_RESET, 1'b0, RCA_GRP_NONE};
    num_errors = 0;
    cmp_count = 0;
    void'($urandom(32'h40F0));
    repeat (5) cycle(1'b0, 1'b0, 10'h000, 7'h00);
    // back-to-back reads, each against a competing accumulator and carry write
    for (int i = 0; i < 4; i++) cycle(1'b1, 1'b1, ops[i], 7'h7F);
    for (int i = 0; i < 4; i++) cycle(1'b1, 1'b0, ops[i], 7'h2B);
    repeat (600) cycle(1'b1, 1'($urandom_range(1, 0)), rnd_word(), rca_core_wr_type'(7'($urandom)));
    // reset in mid-run with a read presented
    repeat (5) cycle(1'b0, 1'b1, ops[3], 7'h7F);
    repeat (600) cycle(1'b1, 1'($urandom_range(1, 0)), rnd_word(), rca_core_wr_type'(7'($urandom)));
    cycle(1'b1, 1'b0, 10'h000, 7'h00);
    close_out();
  end
endmodule : test_read_ctrl_reg_to_acc_ops

`default_nettype wire

/* File: logic/rca_pkg.sv */
// Summary of operation
// RULE1 - word 0x054 copies interrupt control register one into accumulator, one cycle, no skip
// RULE2 - word 0x055 copies interrupt control register two into accumulator, one cycle, no skip
// RULE3 - word 0x24A copies timer control register one into accumulator, one cycle, no skip
// RULE4 - word 0x24C copies timer control register two into accumulator, one cycle, no skip
// RULE5 - timer reads take data from the timer unit and report as timer operations
// RULE6 - reads change nothing but the accumulator; sources see no access side effect
package rca_pkg;

  localparam int RCA_INSTR_W = 10;
  localparam int RCA_DATA_W = 4;

  localparam logic [RCA_INSTR_W-1:0] RCA_OP_READ_INT_CTRL_ONE = 10'h054;
  localparam logic [RCA_INSTR_W-1:0] RCA_OP_READ_INT_CTRL_TWO = 10'h055;
  localparam logic [RCA_INSTR_W-1:0] RCA_OP_READ_TIMER_CTRL_ONE = 10'h24A;
  localparam logic [RCA_INSTR_W-1:0] RCA_OP_READ_TIMER_CTRL_TWO = 10'h24C;

  localparam logic [RCA_DATA_W-1:0] RCA_ACC_RESET = 4'h0;
  localparam logic RCA_CARRY_RESET = 1'b0;
  localparam logic RCA_DONE_RESET = 1'b0;

  // one-hot selection of the read instruction being executed
  typedef enum logic [3:0] {
    RCA_SEL_NONE = 4'b0000,
    RCA_SEL_INT_ONE = 4'b0001,
    RCA_SEL_INT_TWO = 4'b0010,
    RCA_SEL_TMR_ONE = 4'b0100,
    RCA_SEL_TMR_TWO = 4'b1000
  } rca_sel_type;

  // grouping reported for a retired instruction
  typedef enum logic [1:0] {
    RCA_GRP_NONE = 2'b00,
    RCA_GRP_INTERRUPT = 2'b01,
    RCA_GRP_TIMER = 2'b10
  } rca_group_type;

  // peripheral control registers offered to the core
  typedef struct packed {
    logic [RCA_DATA_W-1:0] int_ctrl_reg_one;
    logic [RCA_DATA_W-1:0] int_ctrl_reg_two;
    logic [RCA_DATA_W-1:0] timer_ctrl_reg_one;
    logic [RCA_DATA_W-1:0] timer_ctrl_reg_two;
  } rca_ctrl_regs_type;

  // write request from the rest of the core's instruction set
  typedef struct packed {
    logic acc_wr;
    logic [RCA_DATA_W-1:0] acc_wdata;
    logic carry_wr;
    logic carry_wdata;
  } rca_core_wr_type;

endpackage : rca_pkg

/* File: logic/rca_read_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module rca_read_ctrl
  import rca_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // instruction from fetch
  input wire logic instr_valid_i,
  input wire logic [RCA_INSTR_W-1:0] instr_i,
  // peripheral control registers
  input wire rca_ctrl_regs_type ctrl_regs_i,
  // other instructions writing accumulator and carry
  input wire rca_core_wr_type core_wr_i,
  // core state
  output logic [RCA_DATA_W-1:0] acc_o,
  output logic carry_flag_o,
  // retire information
  output logic exec_done_o,
  output logic skip_o,
  output rca_group_type group_o
);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  function automatic rca_sel_type decode_read(input logic valid, input logic [RCA_INSTR_W-1:0] word);
    rca_sel_type sel;
    sel = RCA_SEL_NONE;
    if (valid) begin
      case (word)
        RCA_OP_READ_INT_CTRL_ONE: sel = RCA_SEL_INT_ONE;
        RCA_OP_READ_INT_CTRL_TWO: sel = RCA_SEL_INT_TWO;
        RCA_OP_READ_TIMER_CTRL_ONE: sel = RCA_SEL_TMR_ONE;
        RCA_OP_READ_TIMER_CTRL_TWO: sel = RCA_SEL_TMR_TWO;
        default: sel = RCA_SEL_NONE;
      endcase
    end
    return sel;
  endfunction : decode_read

  rca_sel_type sel_next;
  logic [RCA_DATA_W-1:0] read_data_next;
  rca_group_type group_next;

  assign sel_next = decode_read(instr_valid_i, instr_i);

  // sources are only observed, never strobed, so a read has no side effect
  always_comb begin
    read_data_next = RCA_ACC_RESET;
    group_next = RCA_GRP_NONE;
    case (sel_next)
      RCA_SEL_INT_ONE: begin
        read_data_next = ctrl_regs_i.int_ctrl_reg_one; // RULE1
        group_next = RCA_GRP_INTERRUPT;
      end
      RCA_SEL_INT_TWO: begin
        read_data_next = ctrl_regs_i.int_ctrl_reg_two; // RULE2
        group_next = RCA_GRP_INTERRUPT;
      end
      RCA_SEL_TMR_ONE: begin
        read_data_next = ctrl_regs_i.timer_ctrl_reg_one; // RULE3
        group_next = RCA_GRP_TIMER; // RULE5
      end
      RCA_SEL_TMR_TWO: begin
        read_data_next = ctrl_regs_i.timer_ctrl_reg_two; // RULE4
        group_next = RCA_GRP_TIMER; // RULE5
      end
      default: begin
        read_data_next = RCA_ACC_RESET;
        group_next = RCA_GRP_NONE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator

  logic [RCA_DATA_W-1:0] acc_reg;

  // one instruction per cycle, so a decoded read outranks a stray foreign write
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      acc_reg <= RCA_ACC_RESET;
    end else if (sel_next != RCA_SEL_NONE) begin
      acc_reg <= read_data_next; // RULE6
    end else if (core_wr_i.acc_wr) begin
      acc_reg <= core_wr_i.acc_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // carry flag

  logic carry_flag_reg;

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      carry_flag_reg <= RCA_CARRY_RESET;
    end else if (sel_next == RCA_SEL_NONE && core_wr_i.carry_wr) begin
      carry_flag_reg <= core_wr_i.carry_wdata; // RULE1 RULE2 RULE3 RULE4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // retire

  logic exec_done_reg;
  rca_group_type group_reg;

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      exec_done_reg <= RCA_DONE_RESET;
      group_reg <= RCA_GRP_NONE;
    end else begin
      exec_done_reg <= (sel_next != RCA_SEL_NONE);
      group_reg <= group_next;
    end
  end

  assign acc_o = acc_reg;
  assign carry_flag_o = carry_flag_reg;
  assign exec_done_o = exec_done_reg;
  assign group_o = group_reg;
  // none of these reads ever skips the next word
  assign skip_o = 1'b0; // RULE1 RULE2 RULE3 RULE4

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_int_one;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (instr_valid_i && instr_i == RCA_OP_READ_INT_CTRL_ONE)
      |=> (acc_o == $past(ctrl_regs_i.int_ctrl_reg_one)) && exec_done_o && group_o == RCA_GRP_INTERRUPT;
  endproperty
  a_int_one: assert property (p_int_one) else $error("int ctrl one read wrong"); // RULE1

  property p_int_two;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (instr_valid_i && instr_i == RCA_OP_READ_INT_CTRL_TWO)
      |=> (acc_o == $past(ctrl_regs_i.int_ctrl_reg_two)) && exec_done_o && group_o == RCA_GRP_INTERRUPT;
  endproperty
  a_int_two: assert property (p_int_two) else $error("int ctrl two read wrong"); // RULE2

  property p_tmr_one;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (instr_valid_i && instr_i == RCA_OP_READ_TIMER_CTRL_ONE)
      |=> (acc_o == $past(ctrl_regs_i.timer_ctrl_reg_one)) && exec_done_o;
  endproperty
  a_tmr_one: assert property (p_tmr_one) else $error("timer ctrl one read wrong"); // RULE3

  property p_tmr_two;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (instr_valid_i && instr_i == RCA_OP_READ_TIMER_CTRL_TWO)
      |=> (acc_o == $past(ctrl_regs_i.timer_ctrl_reg_two)) && exec_done_o;
  endproperty
  a_tmr_two: assert property (p_tmr_two) else $error("timer ctrl two read wrong"); // RULE4

  property p_timer_group;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (instr_valid_i && (instr_i == RCA_OP_READ_TIMER_CTRL_ONE || instr_i == RCA_OP_READ_TIMER_CTRL_TWO))
      |=> group_o == RCA_GRP_TIMER;
  endproperty
  a_timer_group: assert property (p_timer_group) else $error("timer read not grouped as timer"); // RULE5

  property p_carry_kept;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (decode_read(instr_valid_i, instr_i) != RCA_SEL_NONE) |=> $stable(carry_flag_o);
  endproperty
  a_carry_kept: assert property (p_carry_kept) else $error("carry changed by read"); // RULE1

  property p_no_skip;
    @(posedge core_clk_i) disable iff (!resetn_i)
    exec_done_o |-> !skip_o;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("read caused skip"); // RULE2

  property p_acc_only_on_write;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (decode_read(instr_valid_i, instr_i) == RCA_SEL_NONE && !core_wr_i.acc_wr) |=> $stable(acc_o);
  endproperty
  a_acc_only_on_write: assert property (p_acc_only_on_write) else $error("acc changed without write"); // RULE6

  property p_done_one_cycle;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (decode_read(instr_valid_i, instr_i) == RCA_SEL_NONE) |=> !exec_done_o;
  endproperty
  a_done_one_cycle: assert property (p_done_one_cycle) else $error("done without read"); // RULE3

  // a foreign accumulator write must still land when no read competes
  property p_core_acc_write;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (decode_read(instr_valid_i, instr_i) == RCA_SEL_NONE && core_wr_i.acc_wr)
      |=> acc_o == $past(core_wr_i.acc_wdata);
  endproperty
  a_core_acc_write: assert property (p_core_acc_write) else $error("foreign acc write lost"); // RULE6

  property p_carry_write;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (decode_read(instr_valid_i, instr_i) == RCA_SEL_NONE && core_wr_i.carry_wr)
      |=> carry_flag_o == $past(core_wr_i.carry_wdata);
  endproperty
  a_carry_write: assert property (p_carry_write) else $error("foreign carry write lost"); // RULE6

  // the group is reported only together with a retired read
  property p_done_has_group;
    @(posedge core_clk_i) disable iff (!resetn_i)
    exec_done_o == (group_o != RCA_GRP_NONE);
  endproperty
  a_done_has_group: assert property (p_done_has_group) else $error("group without retired read"); // RULE5

  c_int_read: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    exec_done_o && group_o == RCA_GRP_INTERRUPT);
  c_timer_read: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    exec_done_o && group_o == RCA_GRP_TIMER);
  c_back_to_back: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    exec_done_o ##1 exec_done_o);
  c_read_over_write: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    decode_read(instr_valid_i, instr_i) != RCA_SEL_NONE && core_wr_i.acc_wr);

endmodule : rca_read_ctrl

`default_nettype wire
